/* File: smr_regs.sv */
// How it works
// RULE1 - Style bit 2 picks latched level or pulse interrupt pin behaviour.
// RULE2 - Sense bit 3 sets pin active polarity in both modes, reset 0.
// RULE3 - Mask bit 0 lets event reach pin; mask bit 1 blocks it.
// RULE4 - Level mode latches unmasked event until host reads event flags.
// RULE5 - Pulse mode emits one pulse per new unmasked event, never holds.
// RULE6 - Host must not write offsets outside the map.
// RULE7 - Offsets 2h, 7h, 20h to 25h and 27h decode to registers.
// RULE8 - Control resets to 8042h; bits 11 to 7 and 5 read zero.
// RULE9 - Watchdog runs only when bit 12 set; bits 15-13 pick timeout.
// RULE10 - Control bit 6 drives reference power control, reset 1.
// RULE11 - Frame check byte appended and checked only when bit 4 set.
// RULE12 - Float select 1 leaves serial output floating during writes.
// RULE13 - Writing 0001h to software reset restores defaults, flushes queues.
// RULE14 - Event flags stick until written one; live bits follow conditions.
// RULE15 - Interrupt block register resets to 0024h.
// RULE16 - Pulse lasts one clock at active level; sense 0 is low.
// RULE17 - Style 0 is pulse mode, 1 is latched level mode.
`timescale 1ns/100ps
module smr_regs #(
	parameter int CYC_PER_MS = smr_pkg::CLK_HZ / smr_pkg::HZ_PER_KHZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sdi,
	output logic             serial_data_output,
	output logic             sdo_oe_n,
	output logic             irq,
	input  wire logic [15:0] event_set,
	input  wire logic [15:0] live_status,
	input  wire logic [15:0] rx_data,
	output logic             rx_pop,
	output logic             tx_push,
	output logic      [15:0] tx_data,
	output logic             fifo_flush,
	output logic             reference_power_control,
	output logic      [15:0] modem_ctrl,
	output logic      [15:0] queue_thr,
	output logic      [15:0] babble_lim
);

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	smr_pkg::smr_pins_t pins_in;
	smr_pkg::smr_pins_t pins_s;
	smr_pkg::smr_pins_t pins_d;

	assign pins_in = '{sclk: sclk, cs_n: cs_n, sdi: sdi};

	smr_sync #(
		.WIDTH   (3),
		.RST_VAL (smr_pkg::PINS_IDLE)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (pins_in),
		.sync_out (pins_s)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			pins_d <= smr_pkg::PINS_IDLE;
		end else begin
			pins_d <= pins_s;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	assign cs_fall   = pins_d.cs_n & ~pins_s.cs_n;
	assign cs_rise   = ~pins_d.cs_n & pins_s.cs_n;
	assign sclk_rise = ~pins_s.cs_n & ~pins_d.sclk & pins_s.sclk;
	assign sclk_fall = ~pins_s.cs_n & pins_d.sclk & ~pins_s.sclk;

	// ------------------------------------------------------------
	// Frame capture
	// ------------------------------------------------------------
	logic [31:0] sh_r;
	logic [5:0]  cnt_r;
	logic        seen_fall_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			sh_r        <= '0;
			cnt_r       <= '0;
			seen_fall_r <= 1'b0;
		end else if (cs_fall) begin
			cnt_r       <= '0;
			seen_fall_r <= 1'b0;
		end else if (sclk_fall) begin
			sh_r        <= {sh_r[30:0], pins_s.sdi};
			seen_fall_r <= 1'b1;
			if (cnt_r != smr_pkg::LEN_MAX) begin
				cnt_r <= cnt_r + 6'h01;
			end
		end
	end

	smr_pkg::smr_ctrl_t  ctrl_r;
	smr_pkg::smr_frame_t frame_w;
	logic [7:0]          crc_rx_w;
	logic                crc_ok;
	logic                done;
	logic                crc_err;
	logic                wr_en;
	logic                rd_en;

	// Frame is right justified: last 24 or 32 bits count
	// RULE11 - check frame byte
	assign frame_w  = ctrl_r.crc_en ? sh_r[31:8] : sh_r[23:0];
	assign crc_rx_w = sh_r[7:0];
	assign crc_ok   = ~ctrl_r.crc_en | (smr_pkg::crc8(frame_w) == crc_rx_w);
	assign done     = cs_rise &
		(cnt_r >= (ctrl_r.crc_en ? smr_pkg::LEN_CRC : smr_pkg::LEN_PLAIN));
	assign crc_err  = done & ~crc_ok;
	assign wr_en    = done & crc_ok & ~frame_w.rd;
	assign rd_en    = done & crc_ok & frame_w.rd;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic soft_rst;
	logic stat_rd;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic wr_mctl;
	logic wr_txq;
	logic wr_qthr;
	logic wr_babl;

	// RULE7 - offset decode
	// RULE6 - unlisted offsets ignored
	assign wr_ctrl  = wr_en & (frame_w.addr == smr_pkg::ADDR_CTRL);
	assign wr_stat  = wr_en & (frame_w.addr == smr_pkg::ADDR_STAT);
	assign wr_mask  = wr_en & (frame_w.addr == smr_pkg::ADDR_MASK);
	assign wr_mctl  = wr_en & (frame_w.addr == smr_pkg::ADDR_MCTL);
	assign wr_txq   = wr_en & (frame_w.addr == smr_pkg::ADDR_TXQ);
	assign wr_qthr  = wr_en & (frame_w.addr == smr_pkg::ADDR_QTHR);
	assign wr_babl  = wr_en & (frame_w.addr == smr_pkg::ADDR_BABL);
	assign stat_rd  = rd_en & (frame_w.addr == smr_pkg::ADDR_STAT);
	// RULE13 - software reset command
	assign soft_rst = wr_en & (frame_w.addr == smr_pkg::ADDR_SRST) &
		(frame_w.data == smr_pkg::SRST_CMD);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [15:0] mask_r;

	// RULE8 - control reset and reserved bits
	// RULE13 - defaults on software reset
	always_ff @(posedge clk) begin
		if (rst || soft_rst) begin
			ctrl_r     <= smr_pkg::CTRL_RST;
			mask_r     <= smr_pkg::MASK_RST;
			modem_ctrl <= smr_pkg::MCTL_RST;
			queue_thr  <= smr_pkg::QTHR_RST;
			babble_lim <= smr_pkg::BABL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= frame_w.data & smr_pkg::CTRL_WR_MASK;
			end
			// RULE15 - mask storage
			if (wr_mask) begin
				mask_r <= frame_w.data & smr_pkg::MASK_WR_MASK;
			end
			if (wr_mctl) begin
				modem_ctrl <= frame_w.data;
			end
			if (wr_qthr) begin
				queue_thr <= frame_w.data;
			end
			if (wr_babl) begin
				babble_lim <= frame_w.data;
			end
		end
	end

	// RULE10 - reference power control
	assign reference_power_control = ctrl_r.ref_pwr;

	// ------------------------------------------------------------
	// Queue strobes
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_push    <= 1'b0;
			tx_data    <= '0;
			rx_pop     <= 1'b0;
			fifo_flush <= 1'b0;
		end else begin
			tx_push    <= wr_txq;
			rx_pop     <= rd_en & (frame_w.addr == smr_pkg::ADDR_RXQ);
			fifo_flush <= soft_rst;
			if (wr_txq) begin
				tx_data <= frame_w.data;
			end
		end
	end

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	logic [31:0] div_r;
	logic        ms_tick;
	logic [12:0] wd_ms_r;
	logic [12:0] wd_lim;
	logic        wdt_hit_r;

	assign ms_tick = div_r == 32'(CYC_PER_MS - 1);
	assign wd_lim  = smr_pkg::wdog_ms(ctrl_r.wd_sel);

	always_ff @(posedge clk) begin
		if (rst || ms_tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'h1;
		end
	end

	// RULE9 - watchdog enable and period
	always_ff @(posedge clk) begin
		if (rst || !ctrl_r.wd_en || (done && crc_ok)) begin
			wd_ms_r   <= '0;
			wdt_hit_r <= 1'b0;
		end else if (ms_tick) begin
			if (wd_ms_r >= wd_lim - smr_pkg::WD_MS_ONE) begin
				wd_ms_r   <= '0;
				wdt_hit_r <= 1'b1;
			end else begin
				wd_ms_r   <= wd_ms_r + smr_pkg::WD_MS_ONE;
				wdt_hit_r <= 1'b0;
			end
		end else begin
			wdt_hit_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------
	logic [15:0] stat_r;
	logic [15:0] set_w;
	logic [15:0] clr_w;
	logic [15:0] live_d_r;
	logic [15:0] stat_view;

	assign set_w = (event_set & smr_pkg::STICKY_MASK) |
		(wdt_hit_r ? smr_pkg::STAT_WDT_EVT : smr_pkg::RD_NONE) |
		(crc_err ? smr_pkg::STAT_CRC_EVT : smr_pkg::RD_NONE) |
		(soft_rst ? smr_pkg::STAT_RST_EVT : smr_pkg::RD_NONE);
	assign clr_w = wr_stat ? (frame_w.data & smr_pkg::STICKY_MASK) : smr_pkg::RD_NONE;
	assign stat_view = stat_r | (live_status & smr_pkg::LIVE_MASK);

	// RULE14 - sticky flags, set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_r   <= smr_pkg::STAT_RST;
			live_d_r <= '0;
		end else begin
			stat_r   <= ((stat_r & ~clr_w) | set_w) & smr_pkg::STICKY_MASK;
			live_d_r <= live_status & smr_pkg::LIVE_MASK;
		end
	end

	// ------------------------------------------------------------
	// Interrupt pin
	// ------------------------------------------------------------
	logic [15:0] new_evt;
	logic        unmasked;
	logic        pend_r;
	logic        pulse_r;
	logic        act_w;
	logic        irq_r;

	// RULE3 - mask gating
	assign new_evt  = set_w | (live_status & smr_pkg::LIVE_MASK & ~live_d_r);
	assign unmasked = |(new_evt & ~mask_r);

	// RULE4 - latch until flags read
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_r <= 1'b0;
		end else if (unmasked) begin
			pend_r <= 1'b1;
		end else if (stat_rd || soft_rst) begin
			pend_r <= 1'b0;
		end
	end

	// RULE5 - one pulse per event
	// RULE16 - single clock pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= unmasked & ~pulse_r;
		end
	end

	// RULE1 - mode select
	// RULE17 - style 1 is level
	assign act_w = ctrl_r.style ? pend_r : pulse_r;

	// RULE2 - pin polarity
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r <= smr_pkg::IRQ_IDLE;
		end else begin
			irq_r <= ctrl_r.sense ? act_w : ~act_w;
		end
	end

	assign irq = irq_r;

	// ------------------------------------------------------------
	// Read data and response
	// ------------------------------------------------------------
	logic [15:0] rd_data;
	logic [31:0] resp_r;
	logic [31:0] out_sh_r;
	logic        oe_n_r;

	always_comb begin
		unique case (frame_w.addr)
			smr_pkg::ADDR_CTRL: rd_data = ctrl_r;
			smr_pkg::ADDR_SRST: rd_data = smr_pkg::SRST_READ;
			smr_pkg::ADDR_STAT: rd_data = stat_view;
			smr_pkg::ADDR_MASK: rd_data = mask_r;
			smr_pkg::ADDR_MCTL: rd_data = modem_ctrl;
			smr_pkg::ADDR_RXQ:  rd_data = rx_data;
			smr_pkg::ADDR_QTHR: rd_data = queue_thr;
			smr_pkg::ADDR_BABL: rd_data = babble_lim;
			default:            rd_data = smr_pkg::RD_NONE;
		endcase
	end

	// Bad read answers fixed word; bad write leaves echo unchanged
	always_ff @(posedge clk) begin
		if (rst) begin
			resp_r <= '0;
		end else if (crc_err && frame_w.rd) begin
			resp_r <= smr_pkg::BAD_CRC_RESP;
		end else if (rd_en) begin
			resp_r <= {frame_w.rd, frame_w.addr, rd_data,
				smr_pkg::crc8({frame_w.rd, frame_w.addr, rd_data})};
		end else if (wr_en) begin
			resp_r <= {frame_w, crc_rx_w};
		end
	end

	// Shift only after a falling edge so both clock modes align
	always_ff @(posedge clk) begin
		if (rst) begin
			out_sh_r <= '0;
		end else if (cs_fall) begin
			out_sh_r <= resp_r;
		end else if (sclk_rise && seen_fall_r) begin
			out_sh_r <= {out_sh_r[30:0], 1'b0};
		end
	end

	// RULE12 - float during writes
	always_ff @(posedge clk) begin
		if (rst || pins_s.cs_n) begin
			oe_n_r <= 1'b1;
		end else if (cs_fall) begin
			oe_n_r <= 1'b0;
		end else if (sclk_fall && !seen_fall_r && ctrl_r.float_sel && !pins_s.sdi) begin
			oe_n_r <= 1'b1;
		end
	end

	assign serial_data_output      = out_sh_r[31];
	assign sdo_oe_n = oe_n_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_mask_gate: assert property (@(posedge clk) disable iff (rst) // RULE3
		(!pend_r && !unmasked) |=> !pend_r)
		else $error("pending set without unmasked event");

	a_level_latch: assert property (@(posedge clk) disable iff (rst) // RULE4
		(unmasked && ctrl_r.style && !wr_ctrl) |=> ##1 (irq == ctrl_r.sense))
		else $error("level interrupt not asserted");

	a_pulse_width: assert property (@(posedge clk) disable iff (rst) // RULE16
		pulse_r |=> !pulse_r)
		else $error("pulse longer than one cycle");

	a_edge_release: assert property (@(posedge clk) disable iff (rst) // RULE5
		(!ctrl_r.style && !pulse_r && $stable(ctrl_r)) |=> (irq == !$past(ctrl_r.sense)))
		else $error("edge mode pin held active");

	a_ctrl_reset: assert property (@(posedge clk) disable iff (rst) // RULE8
		$past(rst) |-> (ctrl_r == smr_pkg::CTRL_RST && mask_r == smr_pkg::MASK_RST))
		else $error("control or mask reset value wrong");

	a_ctrl_rsvd: assert property (@(posedge clk) disable iff (rst) // RULE8
		(ctrl_r & ~smr_pkg::CTRL_WR_MASK) == smr_pkg::RD_NONE)
		else $error("reserved control bits set");

	a_soft_reset: assert property (@(posedge clk) disable iff (rst) // RULE13
		soft_rst |=> (ctrl_r == smr_pkg::CTRL_RST && modem_ctrl == smr_pkg::MCTL_RST
			&& fifo_flush))
		else $error("software reset incomplete");

	a_sticky_hold: assert property (@(posedge clk) disable iff (rst) // RULE14
		1'b1 |=> ((stat_r & $past(stat_r & ~clr_w)) == $past(stat_r & ~clr_w)))
		else $error("sticky flag lost");

	a_wdog_off: assert property (@(posedge clk) disable iff (rst) // RULE9
		!ctrl_r.wd_en |=> !wdt_hit_r)
		else $error("watchdog fired while disabled");

	a_crc_block: assert property (@(posedge clk) disable iff (rst) // RULE11
		(done && ctrl_r.crc_en && !crc_ok) |-> !wr_en && !rd_en)
		else $error("bad check byte frame accepted");

	a_sdo_float: assert property (@(posedge clk) disable iff (rst) // RULE12
		(sclk_fall && !seen_fall_r && ctrl_r.float_sel && !pins_s.sdi) |=> sdo_oe_n)
		else $error("serial out driven during write");

endmodule

/* File: smr_pkg.sv */
package smr_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int HZ_PER_KHZ  = 1000;
	// Watchdog periods in ms, one per select code
	localparam int WDOG_T0_MS  = 50;
	localparam int WDOG_T1_MS  = 100;
	localparam int WDOG_T2_MS  = 500;
	localparam int WDOG_T3_MS  = 1000;
	localparam int WDOG_T4_MS  = 2000;
	localparam int WDOG_T5_MS  = 3000;
	localparam int WDOG_T6_MS  = 4000;
	localparam int WDOG_T7_MS  = 5000;
	localparam logic [12:0] WD_MS_ONE = 13'h0001;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_CTRL = 7'h02;
	localparam logic [6:0] ADDR_SRST = 7'h07;
	localparam logic [6:0] ADDR_STAT = 7'h20;
	localparam logic [6:0] ADDR_MASK = 7'h21;
	localparam logic [6:0] ADDR_MCTL = 7'h22;
	localparam logic [6:0] ADDR_TXQ  = 7'h23;
	localparam logic [6:0] ADDR_RXQ  = 7'h24;
	localparam logic [6:0] ADDR_QTHR = 7'h25;
	localparam logic [6:0] ADDR_BABL = 7'h27;

	// ------------------------------------------------------------
	// Reset values and field masks
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_RST     = 16'h8042;
	localparam logic [15:0] CTRL_WR_MASK = 16'hf05f;
	localparam logic [15:0] SRST_READ    = 16'h0000;
	localparam logic [15:0] SRST_CMD     = 16'h0001;
	localparam logic [15:0] STAT_RST     = 16'h0000;
	localparam logic [15:0] MASK_RST     = 16'h0024;
	localparam logic [15:0] MASK_WR_MASK = 16'h7fff;
	localparam logic [15:0] MCTL_RST     = 16'h0048;
	localparam logic [15:0] QTHR_RST     = 16'h0000;
	localparam logic [15:0] BABL_RST     = 16'h0000;
	localparam logic [15:0] STICKY_MASK  = 16'h9f00;
	localparam logic [15:0] LIVE_MASK    = 16'h60ff;
	localparam logic [15:0] STAT_RST_EVT = 16'h8000;
	localparam logic [15:0] STAT_WDT_EVT = 16'h0200;
	localparam logic [15:0] STAT_CRC_EVT = 16'h0100;
	localparam logic [15:0] RD_NONE      = 16'h0000;

	// ------------------------------------------------------------
	// Serial frame
	// ------------------------------------------------------------
	localparam logic [5:0]  LEN_PLAIN    = 6'h18;
	localparam logic [5:0]  LEN_CRC      = 6'h20;
	localparam logic [5:0]  LEN_MAX      = 6'h3f;
	localparam logic [7:0]  CRC_POLY     = 8'h07;
	localparam logic [7:0]  CRC_INIT     = 8'h00;
	localparam logic [31:0] BAD_CRC_RESP = 32'h80000000;
	localparam logic [2:0]  PINS_IDLE    = 3'h2;
	localparam logic        IRQ_IDLE     = 1'h1;

	typedef struct packed {
		logic [2:0] wd_sel;
		logic       wd_en;
		logic [4:0] rsv_hi;
		logic       ref_pwr;
		logic       rsv_lo;
		logic       crc_en;
		logic       sense;
		logic       style;
		logic       float_sel;
		logic       echo_sel;
	} smr_ctrl_t;

	typedef struct packed {
		logic       rd;
		logic [6:0] addr;
		logic [15:0] data;
	} smr_frame_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdi;
	} smr_pins_t;

	function automatic logic [12:0] wdog_ms(input logic [2:0] sel);
		case (sel)
			3'h0:    return 13'(WDOG_T0_MS);
			3'h1:    return 13'(WDOG_T1_MS);
			3'h2:    return 13'(WDOG_T2_MS);
			3'h3:    return 13'(WDOG_T3_MS);
			3'h4:    return 13'(WDOG_T4_MS);
			3'h5:    return 13'(WDOG_T5_MS);
			3'h6:    return 13'(WDOG_T6_MS);
			default: return 13'(WDOG_T7_MS);
		endcase
	endfunction

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

endpackage

/* File: smr_sync.sv */
`timescale 1ns/100ps
module smr_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* File: smr_host.sv */
`timescale 1ns/100ps
module smr_host (
	input  wire logic clk,
	input  wire logic serial_data_output,
	input  wire logic sdo_oe_n,
	input  wire logic irq,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi
);
	logic busy;

	initial begin
		busy = 1'b0;
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end

	// ------------------------------------------------------------
	// Idle data line
	// ------------------------------------------------------------
	// Toggles between frames so a stale bit is never mistaken for data
	always @(posedge clk) begin
		if (!busy) begin
			sdi <= ~sdi;
		end
	end

	// ------------------------------------------------------------
	// One frame of nbits, clock idles low
	// ------------------------------------------------------------
	// only offsets the caller asks for
	// A floating data line reads back inverted
	task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
		output logic oe_last);
		busy = 1'b1;
		rx   = '0;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = nbits - 1; i >= 0; i--) begin
			sclk <= 1'b1;
			sdi  <= tx[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			repeat (2) @(posedge clk);
			rx[i]   = sdo_oe_n ? ~serial_data_output : serial_data_output;
			oe_last = sdo_oe_n;
			repeat (2) @(posedge clk);
		end
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
		busy = 1'b0;
	endtask
endmodule

/* File: test_spi_modem_irq_control_regs.sv */
`timescale 1ns/100ps
module test_spi_modem_irq_control_regs;
	typedef struct packed {
		logic        wr;
		logic [6:0]  addr;
		logic [15:0] data;
		logic [15:0] want;
	} smr_row_t;

	logic        clk;
	logic        rst;
	logic        sclk;
	logic        cs_n;
	logic        sdi;
	logic        serial_data_output;
	logic        sdo_oe_n;
	logic        irq;
	logic        rx_pop;
	logic        tx_push;
	logic        fifo_flush;
	logic        ref_pwr;
	logic        oe;
	logic [15:0] event_set;
	logic [15:0] rx_data;
	logic [15:0] tx_data;
	logic [15:0] last_tx;
	logic [15:0] d;
	logic [15:0] mctl;
	logic [15:0] qthr;
	logic [15:0] babl;
	logic [15:0] live;
	logic [31:0] r;
	int          fail_count      = 0;
	int          samples_checked = 0;
	int          push_cnt        = 0;
	int          pop_cnt         = 0;
	int          flush_cnt       = 0;
	int          n;

	smr_row_t rows [21] = '{
		'{1'b0, 7'h02, 16'h0000, 16'h8042},
		'{1'b0, 7'h21, 16'h0000, 16'h0024},
		'{1'b0, 7'h07, 16'h0000, 16'h0000},
		'{1'b0, 7'h22, 16'h0000, 16'h0048},
		'{1'b0, 7'h10, 16'h0000, 16'h0000},
		'{1'b1, 7'h02, 16'hefaf, 16'h0000},
		'{1'b0, 7'h02, 16'h0000, 16'he00f},
		'{1'b1, 7'h22, 16'h1234, 16'h0000},
		'{1'b0, 7'h22, 16'h0000, 16'h1234},
		'{1'b1, 7'h25, 16'h00a5, 16'h0000},
		'{1'b0, 7'h25, 16'h0000, 16'h00a5},
		'{1'b1, 7'h27, 16'h005a, 16'h0000},
		'{1'b0, 7'h27, 16'h0000, 16'h005a},
		'{1'b1, 7'h07, 16'h0002, 16'h0000},
		'{1'b0, 7'h22, 16'h0000, 16'h1234},
		'{1'b1, 7'h23, 16'hc3c3, 16'h0000},
		'{1'b0, 7'h24, 16'h0000, 16'h5a3c},
		'{1'b1, 7'h07, 16'h0001, 16'h0000},
		'{1'b0, 7'h02, 16'h0000, 16'h8042},
		'{1'b0, 7'h21, 16'h0000, 16'h0024},
		'{1'b0, 7'h22, 16'h0000, 16'h0048}
	};

	smr_regs #(
		.CYC_PER_MS(4)
	) dut_u (
		.clk                     (clk),
		.rst                     (rst),
		.sclk                    (sclk),
		.cs_n                    (cs_n),
		.sdi                     (sdi),
		.serial_data_output                     (serial_data_output),
		.sdo_oe_n                (sdo_oe_n),
		.irq                     (irq),
		.event_set               (event_set),
		.live_status             (live),
		.rx_data                 (rx_data),
		.rx_pop                  (rx_pop),
		.tx_push                 (tx_push),
		.tx_data                 (tx_data),
		.fifo_flush              (fifo_flush),
		.reference_power_control (ref_pwr),
		.modem_ctrl              (mctl),
		.queue_thr               (qthr),
		.babble_lim              (babl)
	);

	smr_host host_u (
		.clk      (clk),
		.serial_data_output      (serial_data_output),
		.sdo_oe_n (sdo_oe_n),
		.irq      (irq),
		.sclk     (sclk),
		.cs_n     (cs_n),
		.sdi      (sdi)
	);

	initial clk = 1'b0;
	always #20 clk = ~clk;

	always @(posedge clk) begin
		if (tx_push === 1'b1) begin
			push_cnt <= push_cnt + 1;
			last_tx  <= tx_data;
		end
		if (rx_pop === 1'b1) begin
			pop_cnt <= pop_cnt + 1;
		end
		if (fifo_flush === 1'b1) begin
			flush_cnt <= flush_cnt + 1;
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, want);
		end
	endtask

	task automatic chk1(input logic got, input logic want);
		samples_checked++;
		if (got !== want) begin
			fail_count++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, want);
		end
	endtask

	function automatic logic [7:0] ref_crc(input logic [23:0] w);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		host_u.xfer({8'h00, 1'b0, a, v}, 24, r, oe);
	endtask

	// Checked frame; flip spoils the check byte
	task automatic cx(input logic rdb, input logic [6:0] a, input logic [15:0] v,
		input logic [7:0] flip);
		host_u.xfer({rdb, a, v, ref_crc({rdb, a, v}) ^ flip}, 32, r, oe);
	endtask

	// Answer arrives during the following frame, an unmapped read
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		host_u.xfer({8'h00, 1'b1, a, 16'h0000}, 24, r, oe);
		host_u.xfer({8'h00, 1'b1, 7'h7f, 16'h0000}, 24, r, oe);
		v = r[15:0];
	endtask

	task automatic fire(input logic [15:0] ev);
		@(posedge clk);
		event_set <= ev;
		@(posedge clk);
		event_set <= 16'h0000;
	endtask

	task automatic count_irq(input int cycles, input logic lvl, output int cnt);
		cnt = 0;
		repeat (cycles) begin
			@(posedge clk);
			if (irq === lvl) begin
				cnt++;
			end
		end
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		$display("MISMATCH t=%0t run limit reached", $time);
		stop_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst       = 1'b1;
		event_set = 16'h0000;
		live      = 16'h0000;
		rx_data   = 16'h5a3c;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk1(irq, 1'b1);
		chk1(ref_pwr, 1'b1);
		$display("test reset done");

		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].addr, rows[i].data);
			end else begin
				rd(rows[i].addr, d);
				chk16(d, rows[i].want);
			end
		end
		chk16(last_tx, 16'hc3c3);
		chk16(16'(push_cnt), 16'h0001);
		chk16(16'(pop_cnt), 16'h0001);
		chk16(16'(flush_cnt), 16'h0001);
		chk1(ref_pwr, 1'b1);
		chk16(qthr, 16'h0000);
		chk16(babl, 16'h0000);
		$display("test register table done");

		wr(7'h22, 16'h0048);
		chk1(oe, 1'b1);
		host_u.xfer({8'h00, 1'b1, 7'h7f, 16'h0000}, 24, r, oe);
		chk1(oe, 1'b0);
		wr(7'h02, 16'h8040);
		wr(7'h22, 16'h0048);
		chk1(oe, 1'b0);
		$display("test serial output done");

		wr(7'h20, 16'hffff);
		rd(7'h20, d);
		wr(7'h02, 16'h804e);
		chk1(irq, 1'b0);
		fire(16'h0400);
		repeat (3) @(posedge clk);
		count_irq(20, 1'b1, n);
		chk16(16'(n), 16'h0014);
		rd(7'h20, d);
		chk1(irq, 1'b0);
		chk16(d, 16'h0400);
		rd(7'h20, d);
		chk16(d, 16'h0400);
		wr(7'h20, 16'h0400);
		rd(7'h20, d);
		chk16(d, 16'h0000);
		$display("test level mode done");

		wr(7'h21, 16'h0424);
		fire(16'h0400);
		count_irq(10, 1'b1, n);
		chk16(16'(n), 16'h0000);
		rd(7'h20, d);
		chk16(d, 16'h0400);
		wr(7'h21, 16'h0024);
		wr(7'h20, 16'hffff);
		$display("test mask done");

		for (int s = 0; s < 2; s++) begin
			wr(7'h02, 16'h8042 | 16'(s << 3));
			for (int k = 0; k < 2; k++) begin
				fire(16'h0800);
				count_irq(10, s[0], n);
				chk16(16'(n), 16'h0001);
			end
		end
		$display("test pulse mode done");

		wr(7'h02, 16'h8052);
		cx(1'b0, 7'h22, 16'h1234, 8'hff);
		cx(1'b1, 7'h22, 16'h0000, 8'h00);
		cx(1'b1, 7'h20, 16'h0000, 8'h01);
		chk16(r[23:8], 16'h0048);
		chk16({8'h00, r[7:0]}, {8'h00, ref_crc(r[31:8])});
		chk16(mctl, 16'h0048);
		cx(1'b1, 7'h7f, 16'h0000, 8'h00);
		chk16(r[31:16], 16'h8000);
		chk16(r[15:0], 16'h0000);
		cx(1'b0, 7'h02, 16'h8042, 8'h00);
		rd(7'h20, d);
		chk16(d & 16'h0100, 16'h0100);
		$display("test check byte done");

		wr(7'h02, 16'h1042);
		n = 0;
		while (irq !== 1'b0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk1(n >= 180 && n <= 210, 1'b1);
		wr(7'h02, 16'h8042);
		count_irq(300, 1'b0, n);
		chk16(16'(n), 16'h0000);
		rd(7'h20, d);
		chk16(d & 16'h0200, 16'h0200);
		$display("test watchdog done");

		live <= 16'h0081;
		rd(7'h20, d);
		chk16(d & 16'h00ff, 16'h0081);
		live <= 16'h0000;
		rd(7'h20, d);
		chk16(d & 16'h00ff, 16'h0000);
		$display("test live bits done");

		wr(7'h02, 16'h804a);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk1(irq, 1'b1);
		rd(7'h02, d);
		chk16(d, 16'h8042);
		rd(7'h20, d);
		chk16(d, 16'h0000);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule
